//--- sim/hub_link_properties.sv
// protocol checker for the host to hub command link
`timescale 1ns/1ps
module hub_link_properties #(
  parameter int RESET_LOW_CYCLES = 4
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic wr_last,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic hub_reset_pin_n,
  input wire logic multi_function_pin
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic in_frame_reg;
  int low_cnt_reg;
  ////////////////////////////////////////////////////////////////////////
  // tracks whether a write frame is open
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_frame_reg <= 1'b0;
    end else if (!hub_reset_pin_n) begin
      in_frame_reg <= 1'b0;
    end else if (wr_valid && wr_ready) begin
      in_frame_reg <= in_frame_reg ? !wr_last : (wr_byte == hub_cmd_pkg::ADDR_WRITE);
    end
  end
  // counts edges with the reset pin low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt_reg <= 0;
    end else begin
      low_cnt_reg <= hub_reset_pin_n ? 0 : low_cnt_reg + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // read answer steps
  sequence s_req;
    rd_req;
  endsequence
  sequence s_answer;
    ##1 rd_valid ##1 !rd_valid;
  endsequence
  a_ready_follows_pin: assert property (wr_ready == hub_reset_pin_n)
    else $error("write ready differs from reset pin");
  a_answer_once: assert property (s_req |-> s_answer)
    else $error("read request not answered once");
  a_answer_cause: assert property (rd_valid |-> $past(rd_req))
    else $error("answer byte without request");
  a_answer_holds: assert property (!rd_valid && hub_reset_pin_n && $past(hub_reset_pin_n)
    |-> $stable(rd_byte))
    else $error("answer byte changed without answer");
  a_req_spacing: assert property (rd_req |=> !rd_req)
    else $error("read requests back to back");
  a_write_stands: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte))
    else $error("offered byte withdrawn");
  a_frame_opens: assert property (wr_valid && !in_frame_reg
    |-> wr_byte == hub_cmd_pkg::ADDR_WRITE || (wr_byte == hub_cmd_pkg::ADDR_READ && wr_last))
    else $error("frame opened with bad address byte");
  a_reset_width: assert property ($rose(hub_reset_pin_n) |-> low_cnt_reg == RESET_LOW_CYCLES)
    else $error("reset pin low time wrong");
  a_multi_function_pin_release: assert property ($rose(hub_reset_pin_n) |-> ##[1:8] multi_function_pin)
    else $error("mode pin not released after reset");
  a_multi_function_pin_steady: assert property (!hub_reset_pin_n && !$past(hub_reset_pin_n)
    |-> $stable(multi_function_pin))
    else $error("mode pin moved during reset pulse");
endmodule

//--- sim/hub_reset_sleep_status_cmds_tb.sv
// self-checking bench: host end driving the hub command device end
`timescale 1ns/1ps
module hub_reset_sleep_status_cmds_tb;
  logic clock_i = 1'b0, nrst_i = 1'b0, start = 1'b0, hard = 1'b0, boot = 1'b0, poll = 1'b0;
  logic ce = 1'b1;
  logic [2:0] len = 3'h0;
  logic [39:0] body = 40'h0;
  logic [1:0] rlen = 2'h1;
  logic busy, done, refused, in_shut, srst, ram, sleeping, boot_o, swv, astby, cerr;
  logic [7:0] st, dt, ssel, saddr, sdata;
  logic [1:0] feoff;
  int err_total = 0, checks_done = 0, cycles = 0, seed = 99465, srst_cnt = 0, swv_cnt = 0;
  bit got_ref;
  logic [39:0] wr_tab [4] = '{40'h80090340, 40'h40090340, 40'h020d0040, 40'h00180440};
  logic [7:0] fe_tab [4] = '{8'h01, 8'h00, 8'h02, 8'h02};
  hub_link_if link();
  hub_cmd_device #(.SLEEP_IDLE_CYCLES(4)) u_hub_cmd_device(.clock_i, .nrst_i, .ce_i(ce),
    .link(link.device), .poll_tick_i(poll), .soft_reset_o(srst), .ram_power_o(ram),
    .sleeping_o(sleeping), .bootloader_o(boot_o), .sensor_wr_valid_o(swv),
    .sensor_sel_o(ssel), .sensor_addr_o(saddr), .sensor_data_o(sdata),
    .front_end_power_off_mode_o(feoff), .accel_standby_o(astby), .cmd_error_o(cerr));
  hub_cmd_host #(.CMD_DELAY_CYCLES(2), .RESET_LOW_CYCLES(4), .MULTI_FUNCTION_PIN_HOLD_CYCLES(2))
    u_hub_cmd_host(.clock_i, .nrst_i, .ce_i(ce), .link(link.host), .cmd_start_i(start),
    .cmd_len_i(len), .cmd_bytes_i(body), .rsp_len_i(rlen), .hard_reset_i(hard),
    .boot_to_loader_i(boot), .busy_o(busy), .done_o(done), .refused_o(refused),
    .in_shutdown_o(in_shut), .rsp_status_o(st), .rsp_data_o(dt));
  hub_link_properties #(.RESET_LOW_CYCLES(4)) u_hub_link_properties(.clock_i, .nrst_i,
    .wr_valid(link.wr_valid), .wr_ready(link.wr_ready), .wr_last(link.wr_last),
    .wr_byte(link.wr_byte), .rd_req(link.rd_req), .rd_valid(link.rd_valid),
    .rd_byte(link.rd_byte), .hub_reset_pin_n(link.hub_reset_pin_n),
    .multi_function_pin(link.multi_function_pin));
  // clock, soft reset and forwarded write pulse counters
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (srst === 1'b1) srst_cnt++;
    if (swv === 1'b1) swv_cnt++;
  end
  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("counts: %0d mismatches in %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // expected mode byte of a mode readback
  function automatic logic [7:0] mode_byte(input logic b);
    return b ? hub_cmd_pkg::MODE_IS_BOOT : hub_cmd_pkg::MODE_IS_APP;
  endfunction
  // waits for the host to finish, lowering its request pulses
  task automatic wait_end;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clock_i);
      start = 1'b0;
      hard = 1'b0;
      if (done === 1'b1 || refused === 1'b1) break;
    end
    got_ref = (refused === 1'b1);
    repeat (4) @(negedge clock_i);
  endtask
  task automatic send(input logic [39:0] b, input logic [2:0] n, input logic [1:0] r);
    @(negedge clock_i);
    body = b;
    len = n;
    rlen = r;
    start = 1'b1;
    wait_end();
  endtask
  task automatic hreset(input logic b);
    @(negedge clock_i);
    boot = b;
    hard = 1'b1;
    wait_end();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    send(40'h0040090340, 3'd4, 2'd1);
    check({7'h00, got_ref}, 8'h01);
    hreset(1'b1);
    check({7'h00, boot_o}, 8'h01);
    send(40'h0002, 3'd2, 2'd2);
    check(st, 8'h00);
    check(dt, mode_byte(1'b1));
    hreset(1'b0);
    send(40'h0002, 3'd2, 2'd2);
    check(dt, mode_byte(1'b0));
    $display("test mode readback done");
    repeat (20 + ($random(seed) & 7)) @(negedge clock_i);
    check({7'h00, sleeping}, 8'h01);
    poll = 1'b1;
    @(negedge clock_i);
    poll = 1'b0;
    for (int i = 0; i < 8 && sleeping === 1'b1; i++) @(negedge clock_i);
    check({7'h00, sleeping}, 8'h00);
    // clock enable low freezes both ends: no sleep, no command taken
    ce = 1'b0;
    start = 1'b1;
    repeat (12) @(negedge clock_i);
    start = 1'b0;
    check({6'h00, sleeping, busy}, 8'h00);
    ce = 1'b1;
    send(40'h020001, 3'd3, 2'd1);
    check(srst_cnt[7:0], 8'h01);
    $display("test sleep and soft reset done");
    foreach (wr_tab[i]) send({16'h0, 8'h01, wr_tab[i][15:8], 8'h44}, 3'd3, 2'd1);
    foreach (wr_tab[i]) begin
      send(wr_tab[i], 3'd4, 2'd1);
      check({7'h00, got_ref}, 8'h00);
      check({6'h00, feoff}, fe_tab[i]);
      check({sdata, saddr, ssel} == wr_tab[i][31:8] ? 8'h01 : 8'h00, 8'h01);
    end
    check({7'h00, astby}, 8'h01);
    check(swv_cnt[7:0], 8'h04);
    repeat (4) begin
      send({24'h0, 8'h00, 8'h10 + 8'($random(seed) & 7)}, 3'd2, 2'd1);
      check(st, 8'h01);
      check({7'h00, cerr}, 8'h01);
    end
    $display("test pass-through and bad command done");
    send(40'h010001, 3'd3, 2'd1);
    check({7'h00, ram}, 8'h00);
    check({7'h00, in_shut}, 8'h01);
    send(40'h0002, 3'd2, 2'd2);
    check({7'h00, got_ref}, 8'h01);
    hreset(1'b0);
    check({7'h00, ram}, 8'h01);
    $display("test shutdown done");
    complete_run();
  end
endmodule

//--- verilog/hub_cmd_device.sv
// sensor hub command interpreter: reset, shutdown, mode, sensor power commands
`timescale 1ns/1ps
// Functional notes
// - mode value 0x02 soft-resets the hub
// - mode value 0x01 enters shutdown, RAM off
// - only power cycle or reset pin wakes
// - read mode returns status then 0x08/0x00
// - selector 3 reg 9 data 0x40 resets
// - sensor must be enabled before pass-through
// - selector 3 reg 9 data 0x80 powers off
// - selector 0 reg 0x0d data 0x02 powers off
// - selector 4 reg 0x18 data 0 standby
// - hard reset via reset and mode pins
// - no watchdog supervision anywhere
// - no heartbeat indication
// - sleep between polling periods in application
module hub_cmd_device #(
  parameter int SLEEP_IDLE_CYCLES = hub_cmd_pkg::SLEEP_IDLE_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  hub_link_if.device link,
  input wire logic poll_tick_i,
  output logic soft_reset_o,
  output logic ram_power_o,
  output logic sleeping_o,
  output logic bootloader_o,
  output logic sensor_wr_valid_o,
  output logic [7:0] sensor_sel_o,
  output logic [7:0] sensor_addr_o,
  output logic [7:0] sensor_data_o,
  output logic [1:0] front_end_power_off_mode_o,
  output logic accel_standby_o,
  output logic cmd_error_o
);
  localparam int CNT_W = $clog2(hub_cmd_pkg::MAX_BODY + 1);
  localparam int IDLE_W = $clog2(SLEEP_IDLE_CYCLES + 1);

  logic [7:0] frame_reg [hub_cmd_pkg::MAX_BODY];
  logic [CNT_W-1:0] len_reg;
  logic in_frame_reg;
  logic decode_reg;
  logic shutdown_reg;
  logic boot_reg;
  logic pin_q_reg;
  logic soft_reset_reg;
  logic [hub_cmd_pkg::NUM_SENSORS-1:0] enable_reg;
  logic [7:0] status_reg;
  logic [7:0] rsp_data_reg;
  logic rsp_two_reg;
  logic [1:0] rsp_idx_reg;
  logic rd_valid_reg;
  logic [7:0] rd_byte_reg;
  logic sleeping_reg;
  logic [IDLE_W-1:0] idle_reg;
  logic fwd_reg;
  logic [7:0] fwd_sel_reg;
  logic [7:0] fwd_addr_reg;
  logic [7:0] fwd_data_reg;
  logic opt_a_off_reg;
  logic opt_b_off_reg;
  logic accel_standby_reg;
  logic error_reg;

  logic pin_clear;
  logic clear;
  logic byte_take;
  logic activity;
  // decode results
  logic dec_soft;
  logic dec_shut;
  logic dec_read;
  logic dec_en;
  logic dec_fwd;
  logic [7:0] dec_status;
  logic [7:0] f0;
  logic [7:0] f1;
  logic [7:0] f2;
  logic [7:0] f3;
  logic sel_ok;

  ////////////////////////////////////////////////////////////////////////////
  // pins: reset pin held low clears frame, answer, enable and shutdown state, not the front-end power state
  assign pin_clear = !link.hub_reset_pin_n;
  assign clear = pin_clear || soft_reset_reg;
  assign byte_take = link.wr_valid && link.wr_ready && !shutdown_reg;
  assign activity = link.wr_valid || link.rd_req;
  assign link.wr_ready = link.hub_reset_pin_n;

  // reset pin release latches the mode pin: low selects bootloader
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_q_reg <= 1'b1;
      boot_reg <= 1'b0;
    end else if (ce_i) begin
      pin_q_reg <= link.hub_reset_pin_n;
      if (link.hub_reset_pin_n && !pin_q_reg) begin
        boot_reg <= !link.multi_function_pin;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame collection: 0xaa opens a write, 0xab rewinds the answer
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_frame_reg <= 1'b0;
      len_reg <= '0;
      decode_reg <= 1'b0;
      for (int i = 0; i < hub_cmd_pkg::MAX_BODY; i++) begin
        frame_reg[i] <= 8'h00;
      end
    end else if (ce_i) begin
      decode_reg <= 1'b0;
      if (clear) begin
        in_frame_reg <= 1'b0;
        len_reg <= '0;
      end else if (byte_take) begin
        if (!in_frame_reg) begin
          in_frame_reg <= (link.wr_byte == hub_cmd_pkg::ADDR_WRITE) && !link.wr_last;
          decode_reg <= (link.wr_byte == hub_cmd_pkg::ADDR_WRITE) && link.wr_last;
          len_reg <= '0;
        end else begin
          if (len_reg < CNT_W'(hub_cmd_pkg::MAX_BODY)) begin
            frame_reg[len_reg] <= link.wr_byte;
            len_reg <= len_reg + CNT_W'(1);
          end
          if (link.wr_last) begin
            in_frame_reg <= 1'b0;
            decode_reg <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode of a complete frame
  assign f0 = frame_reg[0];
  assign f1 = frame_reg[1];
  assign f2 = frame_reg[2];
  assign f3 = frame_reg[3];
  assign sel_ok = f1 < 8'(hub_cmd_pkg::NUM_SENSORS);

  always_comb begin
    dec_soft = 1'b0;
    dec_shut = 1'b0;
    dec_read = 1'b0;
    dec_en = 1'b0;
    dec_fwd = 1'b0;
    dec_status = hub_cmd_pkg::STATUS_BAD_CMD;
    if (f0 == hub_cmd_pkg::FAM_SET_MODE && len_reg == CNT_W'(3) &&
        f1 == hub_cmd_pkg::IDX_MODE) begin
      if (f2 == hub_cmd_pkg::MODE_SOFT_RESET) begin
        dec_soft = 1'b1;
        dec_status = hub_cmd_pkg::STATUS_OK;
      end else if (f2 == hub_cmd_pkg::MODE_SHUTDOWN) begin
        dec_shut = 1'b1;
        dec_status = hub_cmd_pkg::STATUS_OK;
      end
    end else if (f0 == hub_cmd_pkg::FAM_READ_MODE && len_reg == CNT_W'(2) &&
                 f1 == hub_cmd_pkg::IDX_MODE) begin
      dec_read = 1'b1;
      dec_status = hub_cmd_pkg::STATUS_OK;
    end else if (f0 == hub_cmd_pkg::FAM_SENSOR_EN && len_reg == CNT_W'(3) && sel_ok) begin
      dec_en = 1'b1;
      dec_status = hub_cmd_pkg::STATUS_OK;
    end else if (f0 == hub_cmd_pkg::FAM_SENSOR_WR && len_reg == CNT_W'(4) && sel_ok) begin
      if (enable_reg[f1[2:0]]) begin
        dec_fwd = 1'b1;
        dec_status = hub_cmd_pkg::STATUS_OK;
      end else begin
        dec_status = hub_cmd_pkg::STATUS_NOT_ENABLED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdown: left only through nrst_i or the reset pin, never by a command
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shutdown_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
    end else if (ce_i) begin
      soft_reset_reg <= decode_reg && dec_soft && !clear;
      if (pin_clear) begin
        shutdown_reg <= 1'b0;
      end else if (decode_reg && dec_shut) begin
        shutdown_reg <= 1'b1;
      end
    end
  end

  // sensor enables and the answer held for the next read frame
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_reg <= '0;
      status_reg <= hub_cmd_pkg::STATUS_OK;
      rsp_data_reg <= 8'h00;
      rsp_two_reg <= 1'b0;
      error_reg <= 1'b0;
    end else if (ce_i) begin
      if (clear) begin
        enable_reg <= '0;
        status_reg <= hub_cmd_pkg::STATUS_OK;
        rsp_two_reg <= 1'b0;
        error_reg <= 1'b0;
      end else if (decode_reg) begin
        status_reg <= dec_status;
        error_reg <= dec_status != hub_cmd_pkg::STATUS_OK;
        rsp_two_reg <= dec_read;
        rsp_data_reg <= boot_reg ? hub_cmd_pkg::MODE_IS_BOOT : hub_cmd_pkg::MODE_IS_APP;
        if (dec_en) begin
          enable_reg[f1[2:0]] <= f2[0];
        end
      end
    end
  end

  // answer bytes: status first, then mode byte when asked for
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_idx_reg <= 2'b00;
      rd_valid_reg <= 1'b0;
      rd_byte_reg <= 8'h00;
    end else if (ce_i) begin
      rd_valid_reg <= 1'b0;
      if (clear) begin
        rsp_idx_reg <= 2'b00;
      end else if (byte_take && !in_frame_reg) begin
        rsp_idx_reg <= 2'b00;
      end else if (link.rd_req && !shutdown_reg) begin
        rd_valid_reg <= 1'b1;
        if (rsp_idx_reg == 2'b00) begin
          rd_byte_reg <= status_reg;
        end else if (rsp_idx_reg == 2'b01 && rsp_two_reg) begin
          rd_byte_reg <= rsp_data_reg;
        end else begin
          rd_byte_reg <= hub_cmd_pkg::RSP_PAD;
        end
        if (rsp_idx_reg != 2'b11) begin
          rsp_idx_reg <= rsp_idx_reg + 2'b01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pass-through writes and the power state they leave in each front end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwd_reg <= 1'b0;
      fwd_sel_reg <= 8'h00;
      fwd_addr_reg <= 8'h00;
      fwd_data_reg <= 8'h00;
      opt_a_off_reg <= 1'b0;
      opt_b_off_reg <= 1'b0;
      accel_standby_reg <= 1'b0;
    end else if (ce_i) begin
      fwd_reg <= decode_reg && dec_fwd && !clear;
      if (decode_reg && dec_fwd && !clear) begin
        fwd_sel_reg <= f1;
        fwd_addr_reg <= f2;
        fwd_data_reg <= f3;
        if (f1 == hub_cmd_pkg::SEL_OPT_A && f2 == hub_cmd_pkg::REG_OPT_A_MODE) begin
          if (f3 == hub_cmd_pkg::OPT_A_SOFT_RESET) begin
            opt_a_off_reg <= 1'b0;
          end else if (f3 == hub_cmd_pkg::OPT_A_POWER_OFF) begin
            opt_a_off_reg <= 1'b1;
          end
        end
        if (f1 == hub_cmd_pkg::SEL_OPT_B && f2 == hub_cmd_pkg::REG_OPT_B_SYS_CTL) begin
          opt_b_off_reg <= f3 == hub_cmd_pkg::OPT_B_POWER_OFF;
        end
        if (f1 == hub_cmd_pkg::SEL_ACCEL && f2 == hub_cmd_pkg::REG_ACCEL_CTL_ONE) begin
          accel_standby_reg <= f3 == hub_cmd_pkg::ACCEL_STANDBY;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-power sleep between polling periods, application mode only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleeping_reg <= 1'b0;
      idle_reg <= '0;
    end else if (ce_i) begin
      if (clear || boot_reg || shutdown_reg || activity || poll_tick_i) begin
        sleeping_reg <= 1'b0;
        idle_reg <= '0;
      end else if (idle_reg == IDLE_W'(SLEEP_IDLE_CYCLES)) begin
        sleeping_reg <= 1'b1;
      end else begin
        idle_reg <= idle_reg + IDLE_W'(1);
      end
    end
  end

  // no watchdog and no heartbeat outputs exist
  assign link.rd_valid = rd_valid_reg;
  assign link.rd_byte = rd_byte_reg;
  assign soft_reset_o = soft_reset_reg;
  assign ram_power_o = !shutdown_reg;
  assign sleeping_o = sleeping_reg;
  assign bootloader_o = boot_reg;
  assign sensor_wr_valid_o = fwd_reg;
  assign sensor_sel_o = fwd_sel_reg;
  assign sensor_addr_o = fwd_addr_reg;
  assign sensor_data_o = fwd_data_reg;
  assign front_end_power_off_mode_o = {opt_b_off_reg, opt_a_off_reg};
  assign accel_standby_o = accel_standby_reg;
  assign cmd_error_o = error_reg;
endmodule

//--- verilog/hub_cmd_host.sv
// host end: sends command frames, reads answers, drives hard reset pins
`timescale 1ns/1ps
module hub_cmd_host #(
  parameter int CMD_DELAY_CYCLES = hub_cmd_pkg::CMD_DELAY_CYCLES,
  parameter int RESET_LOW_CYCLES = hub_cmd_pkg::RESET_LOW_CYCLES,
  parameter int MULTI_FUNCTION_PIN_HOLD_CYCLES = hub_cmd_pkg::MULTI_FUNCTION_PIN_HOLD_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  hub_link_if.host link,
  input wire logic cmd_start_i,
  input wire logic [2:0] cmd_len_i,
  input wire logic [39:0] cmd_bytes_i,
  input wire logic [1:0] rsp_len_i,
  input wire logic hard_reset_i,
  input wire logic boot_to_loader_i,
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic in_shutdown_o,
  output logic [7:0] rsp_status_o,
  output logic [7:0] rsp_data_o
);
  localparam int CNT_W = $clog2(RESET_LOW_CYCLES + CMD_DELAY_CYCLES + MULTI_FUNCTION_PIN_HOLD_CYCLES + 2);

  typedef enum {H_IDLE, H_ADDR_W, H_BODY, H_WAIT, H_ADDR_R, H_READ, H_RD_WAIT,
                H_RST_LOW, H_RST_HOLD} host_state_type;

  host_state_type state_reg;
  logic [39:0] cmd_reg;
  logic [2:0] len_reg;
  logic [2:0] idx_reg;
  logic [1:0] rsp_len_reg;
  logic [1:0] rsp_idx_reg;
  logic [7:0] byte_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic shutdown_reg;
  logic reset_pin_reg;
  logic multi_function_pin_reg;
  logic done_reg;
  logic refused_reg;
  logic [7:0] status_reg;
  logic [7:0] data_reg;
  logic [hub_cmd_pkg::NUM_SENSORS-1:0] enable_reg;
  logic is_shut_cmd;
  logic is_en_cmd;
  logic pass_ok;

  // request checks on the incoming command, enable check on the held command
  assign is_shut_cmd = cmd_bytes_i[7:0] == hub_cmd_pkg::FAM_SET_MODE &&
                       cmd_bytes_i[15:8] == hub_cmd_pkg::IDX_MODE &&
                       cmd_bytes_i[23:16] == hub_cmd_pkg::MODE_SHUTDOWN;
  assign pass_ok = cmd_bytes_i[7:0] != hub_cmd_pkg::FAM_SENSOR_WR ||
                   (cmd_bytes_i[15:8] < 8'(hub_cmd_pkg::NUM_SENSORS) &&
                    enable_reg[cmd_bytes_i[10:8]]);
  assign is_en_cmd = cmd_reg[7:0] == hub_cmd_pkg::FAM_SENSOR_EN;

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= H_IDLE;
      cmd_reg <= '0;
      len_reg <= 3'h0;
      idx_reg <= 3'h0;
      rsp_len_reg <= 2'h0;
      rsp_idx_reg <= 2'h0;
      byte_reg <= 8'h00;
      cnt_reg <= '0;
      shutdown_reg <= 1'b0;
      reset_pin_reg <= 1'b1;
      multi_function_pin_reg <= 1'b1;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      status_reg <= 8'h00;
      data_reg <= 8'h00;
      enable_reg <= '0;
    end else if (ce_i) begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (hard_reset_i) begin
            multi_function_pin_reg <= !boot_to_loader_i;
            reset_pin_reg <= 1'b0;
            cnt_reg <= '0;
            state_reg <= H_RST_LOW;
          end else if (cmd_start_i) begin
            if (shutdown_reg || !pass_ok || cmd_len_i == 3'h0 ||
                cmd_len_i > 3'(hub_cmd_pkg::MAX_BODY)) begin
              refused_reg <= 1'b1;
            end else begin
              cmd_reg <= cmd_bytes_i;
              len_reg <= cmd_len_i;
              rsp_len_reg <= rsp_len_i;
              shutdown_reg <= is_shut_cmd;
              byte_reg <= hub_cmd_pkg::ADDR_WRITE;
              idx_reg <= 3'h0;
              state_reg <= H_ADDR_W;
            end
          end
        end
        H_ADDR_W: begin
          if (link.wr_ready) begin
            byte_reg <= cmd_reg[7:0];
            state_reg <= H_BODY;
          end
        end
        H_BODY: begin
          if (link.wr_ready) begin
            if (idx_reg == len_reg - 3'h1) begin
              cnt_reg <= '0;
              if (shutdown_reg) begin
                done_reg <= 1'b1;
                state_reg <= H_IDLE;
              end else begin
                state_reg <= H_WAIT;
              end
            end else begin
              idx_reg <= idx_reg + 3'h1;
              byte_reg <= cmd_reg[8*(idx_reg+3'h1) +: 8];
            end
          end
        end
        H_WAIT: begin
          if (cnt_reg == CNT_W'(CMD_DELAY_CYCLES)) begin
            byte_reg <= hub_cmd_pkg::ADDR_READ;
            state_reg <= H_ADDR_R;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        H_ADDR_R: begin
          if (link.wr_ready) begin
            rsp_idx_reg <= 2'h0;
            state_reg <= H_READ;
          end
        end
        H_READ: begin
          state_reg <= H_RD_WAIT;
        end
        H_RD_WAIT: begin
          if (link.rd_valid) begin
            if (rsp_idx_reg == 2'h0) begin
              status_reg <= link.rd_byte;
              if (is_en_cmd && link.rd_byte == hub_cmd_pkg::STATUS_OK) begin
                enable_reg[cmd_reg[10:8]] <= cmd_reg[16];
              end
            end else begin
              data_reg <= link.rd_byte;
            end
            if (rsp_idx_reg + 2'h1 >= rsp_len_reg) begin
              done_reg <= 1'b1;
              state_reg <= H_IDLE;
            end else begin
              rsp_idx_reg <= rsp_idx_reg + 2'h1;
              state_reg <= H_READ;
            end
          end
        end
        H_RST_LOW: begin
          if (cnt_reg == CNT_W'(RESET_LOW_CYCLES - 1)) begin
            reset_pin_reg <= 1'b1;
            cnt_reg <= '0;
            state_reg <= H_RST_HOLD;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        H_RST_HOLD: begin
          if (cnt_reg == CNT_W'(MULTI_FUNCTION_PIN_HOLD_CYCLES - 1)) begin
            multi_function_pin_reg <= 1'b1;
            shutdown_reg <= 1'b0;
            enable_reg <= '0;
            done_reg <= 1'b1;
            state_reg <= H_IDLE;
          end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // link drive: byte strobes are combinational, byte value from a register
  assign link.wr_valid = state_reg == H_ADDR_W || state_reg == H_BODY ||
                         state_reg == H_ADDR_R;
  assign link.wr_last = state_reg == H_ADDR_R ||
                        (state_reg == H_BODY && idx_reg == len_reg - 3'h1);
  assign link.wr_byte = byte_reg;
  assign link.rd_req = state_reg == H_READ;
  assign link.hub_reset_pin_n = reset_pin_reg;
  assign link.multi_function_pin = multi_function_pin_reg;
  assign busy_o = state_reg != H_IDLE;
  assign done_o = done_reg;
  assign refused_o = refused_reg;
  assign in_shutdown_o = shutdown_reg;
  assign rsp_status_o = status_reg;
  assign rsp_data_o = data_reg;
endmodule

//--- verilog/hub_cmd_pkg.sv
// constants shared by the hub command device end and the host end
package hub_cmd_pkg;
  // frame address bytes
  localparam logic [7:0] ADDR_WRITE = 8'haa;
  localparam logic [7:0] ADDR_READ = 8'hab;
  // command families and indices
  localparam logic [7:0] FAM_SET_MODE = 8'h01;
  localparam logic [7:0] FAM_READ_MODE = 8'h02;
  localparam logic [7:0] FAM_SENSOR_WR = 8'h40;
  localparam logic [7:0] FAM_SENSOR_EN = 8'h44;
  localparam logic [7:0] IDX_MODE = 8'h00;
  // device-mode values
  localparam logic [7:0] MODE_SHUTDOWN = 8'h01;
  localparam logic [7:0] MODE_SOFT_RESET = 8'h02;
  localparam logic [7:0] MODE_IS_BOOT = 8'h08;
  localparam logic [7:0] MODE_IS_APP = 8'h00;
  // status bytes
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h01;
  localparam logic [7:0] STATUS_NOT_ENABLED = 8'h02;
  localparam logic [7:0] RSP_PAD = 8'hff;
  // sensor selectors, registers and values
  localparam logic [7:0] SEL_OPT_B = 8'h00;
  localparam logic [7:0] SEL_OPT_A = 8'h03;
  localparam logic [7:0] SEL_ACCEL = 8'h04;
  localparam logic [7:0] REG_OPT_A_MODE = 8'h09;
  localparam logic [7:0] OPT_A_SOFT_RESET = 8'h40;
  localparam logic [7:0] OPT_A_POWER_OFF = 8'h80;
  localparam logic [7:0] REG_OPT_B_SYS_CTL = 8'h0d;
  localparam logic [7:0] OPT_B_POWER_OFF = 8'h02;
  localparam logic [7:0] REG_ACCEL_CTL_ONE = 8'h18;
  localparam logic [7:0] ACCEL_STANDBY = 8'h00;
  // frame sizes
  localparam int MAX_BODY = 5;
  localparam int NUM_SENSORS = 8;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_LOW_NS = 10000;
  localparam int RESET_LOW_CYCLES = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MULTI_FUNCTION_PIN_HOLD_NS = 1000;
  localparam int MULTI_FUNCTION_PIN_HOLD_CYCLES = (MULTI_FUNCTION_PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_DELAY_NS = 2000;
  localparam int CMD_DELAY_CYCLES = (CMD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_IDLE_NS = 4000;
  localparam int SLEEP_IDLE_CYCLES = (SLEEP_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- verilog/hub_link_if.sv
// byte-level command link between host and hub, plus reset and mode pins
`timescale 1ns/1ps
interface hub_link_if;
  logic wr_valid;
  logic wr_ready;
  logic wr_last;
  logic [7:0] wr_byte;
  logic rd_req;
  logic rd_valid;
  logic [7:0] rd_byte;
  logic hub_reset_pin_n;
  logic multi_function_pin;
  modport device(
    input wr_valid, wr_last, wr_byte, rd_req, hub_reset_pin_n, multi_function_pin,
    output wr_ready, rd_valid, rd_byte
  );
  modport host(
    output wr_valid, wr_last, wr_byte, rd_req, hub_reset_pin_n, multi_function_pin,
    input wr_ready, rd_valid, rd_byte
  );
endinterface
